// file: ioc_irq_output.sv
// Purpose: Interrupt output stage: flags, enables, quiet interval, pin drive and identity
// Assumes: Register strobes and source events are synchronous to CLK_SYS
// Notes: Read data are registered and valid one cycle after the read strobe
// Notes on behaviour
// R01: Quiet interval length is bits 31:24 of output config, one count per 10 us.
// R02: Writing zero length stops the interval, clears its counter, delivers pending interrupts.
// R03: A new non-zero length governs every later interval.
// R04: Wake event interrupt bypasses the quiet interval.
// R05: Writing one to bit 14 clears the counter and starts a fresh interval.
// R06: Bit 13 reads one during an interval; interrupts are then held off the pin.
// R07: Read-only bit 12 shows the internal request line, ignoring pin enable and interval.
// R08: Bit 8 zero holds the pin deasserted; internal flags are untouched.
// R09: Bit 4 picks active high (one) or active low (zero) for push-pull.
// R10: Bit 0 zero makes the pin open-drain active low; one makes it push-pull.
// R11: Output config sits at 54h, 32 bits, resets to zero.
// R12: Identity at 50h returns design code in 31:16, revision in 15:0.
// R13: Polarity and buffer type survive soft reset; only system reset clears them.
// R14: Host writes one to a flag at 58h to clear it; zeros leave flags alone.
// R15: Each fall of the delivered pin starts a quiet interval holding off reassertion.
// R16: Internal request is the OR of every flag ANDed with its enable.
`timescale 1ns/1ns
`include "ioc_consts.svh"
module ioc_irq_output
	import ioc_pkg::*;
#(
	parameter logic [15:0] DESIGN_CODE = 16'hA5C3, // Arbitrary value
	parameter logic [15:0] REVISION = 16'h0001 // Arbitrary value
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic SOFT_RESET,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] SRC_EVENT,
	output logic [31:0] REG_RDATA,
	output logic REG_RVALID,
	output logic IRQ_O,
	output logic IRQ_OE
);
	ioc_top_state_t q;
	ioc_top_state_t next_q;
	ioc_quiet_if qi ();

	logic request;
	logic wake;
	logic wr_cfg;
	logic wr_flags;
	logic wr_en;

	// Register select for a given offset
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Pin level for a given assertion, buffer type and polarity
	function automatic logic pin_level(input logic asserted, input logic pp, input logic pol);
		pin_level = pp ? (asserted ~^ pol) : 1'b0; // [R09] [R10]
	endfunction

	// Quiet interval timer
	ioc_quiet_timer u_timer (
		.clk(CLK_SYS),
		.reset(RESET),
		.soft_reset(SOFT_RESET),
		.qi(qi.timer)
	);

	// Write decode and request merge
	always_comb begin
		wr_cfg = REG_WR && hit(REG_ADDR, `IOC_OFS_OUT_CFG);
		wr_flags = REG_WR && hit(REG_ADDR, `IOC_OFS_FLAGS);
		wr_en = REG_WR && hit(REG_ADDR, `IOC_OFS_ENABLES);
		request = |(q.interrupt_flags & q.enables); // [R16]
		wake = q.interrupt_flags[`IOC_WAKE_BIT] && q.enables[`IOC_WAKE_BIT];
	end

	// Controls toward the timer
	assign qi.length = q.quiet_interval_length; // [R01]
	assign qi.restart = wr_cfg && REG_WDATA[`IOC_CFG_RESTART]; // [R05]
	assign qi.start = q.delivered && !next_q.delivered; // [R15]

	// Next state of registers, delivery and pin
	always_comb begin
		next_q = q;
		next_q.rvalid = 1'b0;
		if (wr_cfg) begin
			next_q.quiet_interval_length = REG_WDATA[`IOC_CFG_LEN_HI:`IOC_CFG_LEN_LO]; // [R01] [R03]
			next_q.pin_en = REG_WDATA[`IOC_CFG_PIN_EN];
			next_q.pin_polarity_select = REG_WDATA[`IOC_CFG_POLARITY];
			next_q.push_pull = REG_WDATA[`IOC_CFG_PUSH_PULL];
		end
		if (wr_en) begin
			next_q.enables = REG_WDATA;
		end
		// New events win over a clear in the same cycle
		next_q.interrupt_flags = (q.interrupt_flags & ~(wr_flags ? REG_WDATA : 32'h00000000)) | SRC_EVENT; // [R14]
		// Soft reset clears all but polarity and buffer type
		if (SOFT_RESET) begin
			next_q.quiet_interval_length = `IOC_RST_LEN;
			next_q.pin_en = 1'b0;
			next_q.interrupt_flags = `IOC_RST_WORD;
			next_q.enables = `IOC_RST_WORD; // [R13]
		end
		// Delivery: held off in an interval except the wake event
		next_q.delivered = q.pin_en && (wake || (request && !qi.active)); // [R04] [R06] [R08] [R02]
		next_q.irq_o = pin_level(next_q.delivered, next_q.push_pull, next_q.pin_polarity_select);
		next_q.irq_oe = next_q.push_pull || next_q.delivered; // [R10]
		// Registered read data; unmapped offsets read zero
		if (REG_RD) begin
			next_q.rvalid = 1'b1;
			next_q.rdata = 32'h00000000;
			if (hit(REG_ADDR, `IOC_OFS_IDENTITY)) begin
				next_q.rdata = {DESIGN_CODE, REVISION}; // [R12]
			end else if (hit(REG_ADDR, `IOC_OFS_OUT_CFG)) begin
				next_q.rdata[`IOC_CFG_LEN_HI:`IOC_CFG_LEN_LO] = q.quiet_interval_length;
				next_q.rdata[`IOC_CFG_ACTIVE] = qi.active; // [R06]
				next_q.rdata[`IOC_CFG_REQUEST] = request; // [R07]
				next_q.rdata[`IOC_CFG_PIN_EN] = q.pin_en;
				next_q.rdata[`IOC_CFG_POLARITY] = q.pin_polarity_select;
				next_q.rdata[`IOC_CFG_PUSH_PULL] = q.push_pull;
			end else if (hit(REG_ADDR, `IOC_OFS_FLAGS)) begin
				next_q.rdata = q.interrupt_flags;
			end else if (hit(REG_ADDR, `IOC_OFS_ENABLES)) begin
				next_q.rdata = q.enables;
			end
		end
	end

	// State register; system reset clears everything
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			q <= '0; // [R11] [R13]
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from flip-flops
	assign REG_RDATA = q.rdata;
	assign REG_RVALID = q.rvalid;
	assign IRQ_O = q.irq_o;
	assign IRQ_OE = q.irq_oe;
endmodule

// file: ioc_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the interrupt output stage
// Assumes: 100 MHz system clock
// Notes: Included by the top module and the quiet interval timer
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// Register offsets
`define IOC_OFS_IDENTITY 8'h50
`define IOC_OFS_OUT_CFG 8'h54
`define IOC_OFS_FLAGS 8'h58
`define IOC_OFS_ENABLES 8'h5C

// Output configuration fields
`define IOC_CFG_LEN_HI 31
`define IOC_CFG_LEN_LO 24
`define IOC_CFG_RESTART 14
`define IOC_CFG_ACTIVE 13
`define IOC_CFG_REQUEST 12
`define IOC_CFG_PIN_EN 8
`define IOC_CFG_POLARITY 4
`define IOC_CFG_PUSH_PULL 0

// Wake event source position in the flags
`define IOC_WAKE_BIT 17

// Reset values
`define IOC_RST_WORD 32'h00000000
`define IOC_RST_LEN 8'h00

// Timing: quiet interval unit and clock period
`define IOC_QUIET_UNIT_NS 10000
`define IOC_CLK_PERIOD_NS 10
`define IOC_TICK_CYCLES (`IOC_QUIET_UNIT_NS / `IOC_CLK_PERIOD_NS)
`define IOC_TICK_LAST 10'(`IOC_TICK_CYCLES - 1)

`endif

// file: ioc_pkg.sv
// Purpose: Types shared by the interrupt output stage modules
// Assumes: ioc_consts.svh holds the numbers
// Notes: State records for the top module and the quiet interval timer
package ioc_pkg;

	// Top module state
	typedef struct packed {
		logic [7:0] quiet_interval_length;
		logic pin_en;
		logic pin_polarity_select;
		logic push_pull;
		logic [31:0] interrupt_flags;
		logic [31:0] enables;
		logic delivered;
		logic irq_o;
		logic irq_oe;
		logic [31:0] rdata;
		logic rvalid;
	} ioc_top_state_t;

	// Quiet interval timer state
	typedef struct packed {
		logic active;
		logic [7:0] count;
		logic [9:0] div;
	} ioc_timer_state_t;

endpackage

// file: ioc_quiet_if.sv
// Purpose: Carrier between the output stage and its quiet interval timer
// Assumes: One clock domain
// Notes: Strobes are one-cycle and combinational from the controller
`timescale 1ns/1ns
interface ioc_quiet_if;
	logic [7:0] length;
	logic restart;
	logic start;
	logic active;

	modport ctrl (output length, output restart, output start, input active);
	modport timer (input length, input restart, input start, output active);
endinterface

// file: ioc_quiet_timer.sv
// Purpose: Times the quiet interval in 10 us units
// Assumes: Length, restart and start arrive from the controller in the same clock domain
// Notes: Length is compared live, so a newly written length governs the next interval
`timescale 1ns/1ns
`include "ioc_consts.svh"
module ioc_quiet_timer
	import ioc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic soft_reset,
	ioc_quiet_if.timer qi
);
	ioc_timer_state_t q;
	ioc_timer_state_t next_q;

	// Next state of the interval counter and 10 us divider
	always_comb begin
		next_q = q;
		if (soft_reset || qi.length == `IOC_RST_LEN) begin
			next_q.active = 1'b0; // [R02]
			next_q.count = 8'h00;
			next_q.div = 10'h000;
		end else if (qi.restart || qi.start) begin
			next_q.active = 1'b1; // [R05] [R15]
			next_q.count = 8'h00;
			next_q.div = 10'h000;
		end else if (q.active) begin
			if (q.div == `IOC_TICK_LAST) begin
				next_q.div = 10'h000; // [R01]
				if (q.count + 8'h01 >= qi.length) begin
					next_q.active = 1'b0; // [R03]
					next_q.count = 8'h00;
				end else begin
					next_q.count = q.count + 8'h01;
				end
			end else begin
				next_q.div = q.div + 10'h001;
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign qi.active = q.active;
endmodule

// file: ioc_host_model.sv
// Purpose: Host side of the interrupt pin
// Assumes: Pull-up on the pin wire
// Notes: Gives the level the host input sees
`timescale 1ns/1ns
module ioc_host_model (
	input wire logic irq_o,
	input wire logic irq_oe,
	output logic pin
);
	// Released pin rests at the pull-up level
	assign pin = irq_oe ? irq_o : 1'b1;
endmodule

// file: ioc_irq_output_properties.sv
// Purpose: Port checks of the interrupt output stage
// Assumes: One clock, RESET async high
// Notes: Bound to the top module
`timescale 1ns/1ns
module ioc_irq_output_props #(
	parameter logic [15:0] DESIGN_CODE = 16'h0001, // Arbitrary value
	parameter logic [15:0] REVISION = 16'h0001 // Arbitrary value
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic SOFT_RESET,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic IRQ_O,
	input wire logic IRQ_OE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Config write with the pin disabled
	wire logic cw = REG_WR && REG_ADDR == 8'h54 && !REG_WDATA[8];
	property p_rd; REG_RD |=> REG_RVALID; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_rv; REG_RVALID |-> $past(REG_RD); endproperty
	a_rv: assert property (p_rv) else $error("read valid without read");
	property p_id; REG_RD && REG_ADDR == 8'h50 |=> REG_RDATA == {DESIGN_CODE, REVISION}; endproperty
	a_id: assert property (p_id) else $error("identity wrong");
	property p_un; REG_RD && !(REG_ADDR inside {8'h50, 8'h54, 8'h58, 8'h5C}) |=> REG_RDATA == 32'h0; endproperty
	a_un: assert property (p_un) else $error("unmapped read not zero");
	property p_hold; !REG_RVALID && !$past(SOFT_RESET) |-> $stable(REG_RDATA); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst; $fell(RESET) |-> !IRQ_OE && !REG_RVALID; endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_off; cw && !REG_WDATA[0] ##1 !REG_WR |=> !IRQ_OE; endproperty
	a_off: assert property (p_off) else $error("open drain pin not released");
	property p_pp; cw && REG_WDATA[0] ##1 !REG_WR |=> IRQ_OE && IRQ_O == !$past(REG_WDATA[4], 2); endproperty
	a_pp: assert property (p_pp) else $error("push-pull idle level wrong");
endmodule
bind ioc_irq_output ioc_irq_output_props #(.DESIGN_CODE(DESIGN_CODE), .REVISION(REVISION)) ioc_irq_output_props_i (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .SOFT_RESET(SOFT_RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
	.IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE));

// file: test_irq_output_control.sv
// Purpose: Register and pin tests of the interrupt output stage
// Assumes: 100 MHz clock, one quiet unit is 1000 cycles
// Notes: Pin level is read through the host model
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("Error %0t %h %h", $time, g, e); end end
module test_irq_output_control;
	logic CLK_SYS = 0, RESET = 1, SOFT_RESET = 0, REG_WR = 0, REG_RD = 0, REG_RVALID, IRQ_O, IRQ_OE, pin;
	logic [7:0] REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0, SRC_EVENT = 32'h0, REG_RDATA;
	int fails = 0, cmp_count = 0, n;
	// Identity values are arbitrary
	ioc_irq_output #(.DESIGN_CODE(16'h3C5A), .REVISION(16'h0002)) ioc_irq_output_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
		.SOFT_RESET(SOFT_RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
		.SRC_EVENT(SRC_EVENT), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE));
	ioc_host_model ioc_host_model_i (.irq_o(IRQ_O), .irq_oe(IRQ_OE), .pin(pin));
	initial forever #5 CLK_SYS = ~CLK_SYS;
	// Verdict and end of run
	task automatic finish_test();
		$display("Compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Bus cycles, one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1;
		`CHK(REG_RVALID, 1'b1)
		`CHK(REG_RDATA, e)
	endtask
	// One-cycle source event
	task automatic ev(input int b);
		@(posedge CLK_SYS);
		SRC_EVENT <= 32'h1 << b;
		@(posedge CLK_SYS);
		SRC_EVENT <= 32'h0;
	endtask
	// Bounded wait for a pin level, cycles waited in n
	task automatic wt(input logic lv, input int mx);
		n = 0;
		#1;
		while (pin !== lv) begin
			@(posedge CLK_SYS);
			#1;
			n++;
			if (n > mx) begin
				fails++;
				finish_test();
			end
		end
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge CLK_SYS);
		RESET <= 1'b0;
		rd(8'h54, 32'h0);
		wr(8'h50, 32'hFFFFFFFF);
		rd(8'h50, 32'h3C5A0002);
		rd(8'h60, 32'h0);
		ev(1);
		rd(8'h54, 32'h0);
		wr(8'h5C, 32'h1);
		wr(8'h54, 32'h100);
		ev(0);
		wt(0, 5);
		`CHK(IRQ_OE, 1'b1)
		wr(8'h54, 32'h0);
		wt(1, 5);
		rd(8'h54, 32'h1000);
		wr(8'h54, 32'h111);
		wt(1, 5);
		wr(8'h54, 32'h101);
		wt(0, 5);
		wr(8'h54, 32'h110);
		wt(0, 5);
		`CHK(IRQ_O, 1'b0)
		wr(8'h58, 32'h1);
		rd(8'h58, 32'h2);
		wr(8'h58, 32'h2);
		wr(8'h54, 32'h01000111);
		ev(0);
		wt(1, 5);
		wr(8'h58, 32'h1);
		rd(8'h54, 32'h01002111);
		ev(0);
		wt(1, 1100);
		`CHK(n > 900, 1'b1)
		wr(8'h5C, 32'h00020001);
		wr(8'h58, 32'h1);
		ev(17);
		wt(1, 5);
		wr(8'h58, 32'h20000);
		ev(0);
		rd(8'h54, 32'h01003111);
		wr(8'h54, 32'h111);
		wt(1, 5);
		wr(8'h58, 32'h1);
		// Length first: a restart only runs against a non-zero stored length
		wr(8'h54, 32'h02000111);
		wr(8'h54, 32'h02004111);
		ev(0);
		wt(1, 2200);
		`CHK(n > 1800, 1'b1)
		@(posedge CLK_SYS);
		SOFT_RESET <= 1'b1;
		@(posedge CLK_SYS);
		SOFT_RESET <= 1'b0;
		rd(8'h54, 32'h11);
		rd(8'h5C, 32'h0);
		wr(8'h54, 32'h11);
		rd(8'h54, 32'h11);
		finish_test();
	end
endmodule
